// >>> tdmsc_top.v
// Clock, frame-sync and rate front end of a multi-link TDM serial port, with its receive buffer
`timescale 1ns/1ns
`include "tdmsc_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Receive buffer: plain circular FIFO with honest full and empty
module tdmsc_fifo #(
  parameter W = `TDMSC_FIFO_W,
  parameter D = `TDMSC_FIFO_D,
  parameter AW = `TDMSC_FIFO_AW
) (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_clk_en,
  input wire i_flush,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rd_q[AW-1:0]];

  always @(posedge i_ref_clk) begin
    if (!i_nrst || (i_clk_en && i_flush)) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else if (i_clk_en) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Storage needs no reset; pointers define what is valid
  always @(posedge i_ref_clk) begin
    if (i_clk_en && push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// How it works
// RL1: Far end supplies steady clock, timeslots times bits per frame, 1024 by default.
// RL2: Frame syncs before frame end ignored; extra clocks after it ignored until sync.
// RL3: Six options from clock mode and line rate: single or double clock per rate.
// RL4: Active links shrink with rate: eight, four, then two.
// RL5: Timeslots per link 128, 256, 512 so the total stays constant.
// RL6: Unused links get the same disabled driver state as disabled timeslots.
// RL7: Default shared clock, sync and rate; primary times all inputs and outputs.
// RL8: Software swaps primary and backup by rewriting config, losing a few frames.
// RL9: Redundancy bit 4: zero makes both follow transmit settings, one independent.
// RL10: Independent mode keeps a backup source in each direction, chosen separately.
// RL11: Clock mode bit 0: zero double-rate clock, one single-rate clock.
// RL12: Double rate takes two sample edges per bit, phase set by sync edge.
// RL13: Rate field bits 2-1: 00 low, 01 mid, 10 high, 11 reserved.
// RL14: Source bit 0 picks first or second clock and sync pair.
// RL15: All receive links share one clock and sync; likewise all transmit links.
// RL16: Data and sync sampling edges chosen separately, per direction.
// RL17: Sync polarity bit 7: zero active low, one active high.
// RL18: Reset leaves double clocking selected; single available at every rate.
// RL19: Polarity fields are write protected while that direction is enabled.
module tdmsc_top (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_clk_en,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_first_serial_clock_in,
  input wire i_first_frame_sync_in,
  input wire i_second_serial_clock_in,
  input wire i_second_frame_sync_in,
  input wire [7:0] i_rx_data,
  output reg [7:0] o_tx_data,
  output reg [7:0] o_tx_oe_n,
  output reg [7:0] o_rx_word,
  output reg o_rx_valid,
  input wire i_rx_ready,
  input wire [7:0] i_tx_word,
  input wire i_tx_valid,
  output reg o_tx_ready
);
  localparam NPIN = 12;
  localparam DRX = 0;
  localparam DTX = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] glb_q;
  reg [1:0] src_q;
  reg [7:0] ctrl_q [0:1];
  reg ovr_q;
  reg undr_q;
  wire [1:0] run_w;
  wire [1:0] stb_w;
  wire [1:0] start_w;
  wire [1:0] en_w = {glb_q[`TDMSC_GC_TX_EN], glb_q[`TDMSC_GC_RX_EN]};
  wire clock_redundancy_select = glb_q[`TDMSC_GC_CLOCK_REDUNDANCY_SELECT];

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once stages two and three agree
  wire [NPIN-1:0] pin_raw = {i_rx_data, i_second_frame_sync_in, i_second_serial_clock_in,
    i_first_frame_sync_in, i_first_serial_clock_in};
  reg [NPIN-1:0] s1_q;
  reg [NPIN-1:0] s2_q;
  reg [NPIN-1:0] s3_q;
  reg [NPIN-1:0] pin_q;
  reg [NPIN-1:0] pin_p_q;

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          pin_q[g] <= 1'b0;
          pin_p_q[g] <= 1'b0;
        end else if (i_clk_en) begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            pin_q[g] <= s3_q[g];
          end
          pin_p_q[g] <= pin_q[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Per-direction clock selection, edge choice and frame tracking
  wire [1:0] rate_w [0:1];
  wire [7:0] links_w [0:1];

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_dir
      // Shared mode takes transmit source, mode and rate; polarities stay per direction
      wire [7:0] cfg = clock_redundancy_select ? ctrl_q[g] : ctrl_q[DTX]; // RL9 RL7
      wire src = clock_redundancy_select ? src_q[g] : src_q[DTX]; // RL9 RL10
      wire single = cfg[`TDMSC_CT_MODE]; // RL11
      wire [1:0] rate = cfg[`TDMSC_CT_RATE_HI:`TDMSC_CT_RATE_LO];
      wire dpol = ctrl_q[g][`TDMSC_CT_DPOL];
      wire fpol = ctrl_q[g][`TDMSC_CT_FPOL];
      wire spol = ctrl_q[g][`TDMSC_CT_SPOL];
      // One pair feeds every link of the direction
      wire ck = src ? pin_q[2] : pin_q[0]; // RL14 RL15
      wire ck_p = src ? pin_p_q[2] : pin_p_q[0]; // RL14 RL15
      wire fs = src ? pin_q[3] : pin_q[1]; // RL14
      wire rise = ck & ~ck_p;
      wire fall = ~ck & ck_p;
      wire fs_act = spol ? fs : ~fs; // RL17
      wire sync_edge = fpol ? fall : rise; // RL16
      wire data_edge = single ? (dpol ? fall : rise) : (rise | fall); // RL16 RL12
      reg run_q;
      reg half_q;
      reg [13:0] cnt_q;
      reg [13:0] len;
      reg [7:0] links;
      // Frame length in bits grows with rate so timeslots per link scale too
      always @* begin
        case (rate) // RL13 RL4 RL5 RL3
          `TDMSC_RATE_LOW: begin
            len = `TDMSC_FRAME_BITS;
            links = `TDMSC_LINKS_LOW;
          end
          `TDMSC_RATE_MID: begin
            len = `TDMSC_FRAME_BITS << 1;
            links = `TDMSC_LINKS_MID;
          end
          `TDMSC_RATE_HIGH: begin
            len = `TDMSC_FRAME_BITS << 2;
            links = `TDMSC_LINKS_HIGH;
          end
          default: begin
            // Reserved code: every link disabled, frame never opens
            len = `TDMSC_FRAME_BITS;
            links = `TDMSC_LINKS_NONE;
          end
        endcase
      end
      wire bit_stb = data_edge & (single | half_q); // RL12
      wire start = en_w[g] & ~run_q & sync_edge & fs_act & (links != `TDMSC_LINKS_NONE); // RL2
      always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
          run_q <= 1'b0;
          half_q <= 1'b0;
          cnt_q <= 14'h0000;
        end else if (i_clk_en) begin
          if (!en_w[g]) begin
            run_q <= 1'b0;
            half_q <= 1'b0;
            cnt_q <= 14'h0000;
          end else if (start) begin
            // Bit phase of a double-rate clock follows the sync detection edge
            run_q <= 1'b1; // RL2
            half_q <= 1'b0; // RL12
            cnt_q <= 14'h0000;
          end else if (run_q && data_edge) begin
            half_q <= single ? 1'b0 : ~half_q; // RL12
            if (bit_stb) begin
              // Syncs are ignored while counting; clocks past the end are ignored
              if (cnt_q == len - 14'h0001) begin
                run_q <= 1'b0; // RL2
                cnt_q <= 14'h0000;
              end else begin
                cnt_q <= cnt_q + 14'h0001;
              end
            end
          end
        end
      end
      assign run_w[g] = run_q;
      assign stb_w[g] = run_q & bit_stb & ~start;
      assign start_w[g] = start;
      assign rate_w[g] = rate;
      assign links_w[g] = links;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Receive path: one masked sample word per bit, through the buffer
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire rx_take = !o_rx_valid || i_rx_ready;
  wire [7:0] rx_sample = pin_q[11:4] & links_w[DRX]; // RL4 RL6

  tdmsc_fifo #(
    .W(`TDMSC_FIFO_W),
    .D(`TDMSC_FIFO_D),
    .AW(`TDMSC_FIFO_AW)
  ) u_rx_fifo (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_flush(~en_w[DRX]),
    .i_in_valid(stb_w[DRX]),
    .o_in_ready(fifo_in_ready),
    .i_in_data(rx_sample),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(rx_take),
    .o_out_data(fifo_out_data)
  );

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_rx_valid <= 1'b0;
      o_rx_word <= 8'h00;
    end else if (i_clk_en) begin
      if (rx_take) begin
        o_rx_valid <= fifo_out_valid;
        if (fifo_out_valid) begin
          o_rx_word <= fifo_out_data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit path: holding word moves to the pins on each transmit bit
  reg [7:0] hold_q;
  reg hold_v_q;
  wire tx_take = i_tx_valid && o_tx_ready;

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      hold_q <= 8'h00;
      hold_v_q <= 1'b0;
      o_tx_ready <= 1'b0;
      o_tx_data <= 8'h00;
      o_tx_oe_n <= 8'hff;
    end else if (i_clk_en) begin
      if (tx_take) begin
        hold_q <= i_tx_word;
        hold_v_q <= 1'b1;
      end else if (stb_w[DTX]) begin
        hold_v_q <= 1'b0;
      end
      // Ready only while the holding word is free and transmit is enabled
      o_tx_ready <= en_w[DTX] && !(hold_v_q || tx_take) || (stb_w[DTX] && !tx_take);
      if (!en_w[DTX] || !run_w[DTX]) begin
        o_tx_data <= 8'h00;
        o_tx_oe_n <= 8'hff;
      end else if (stb_w[DTX]) begin
        // Inactive links and empty bits share one disabled state: released, data low
        o_tx_data <= hold_v_q ? (hold_q & links_w[DTX]) : 8'h00; // RL6
        o_tx_oe_n <= hold_v_q ? ~links_w[DTX] : 8'hff; // RL4 RL6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, then pready for one cycle
  wire acc = i_psel && i_penable && !o_pready;
  wire hit_glb = (i_paddr == `TDMSC_OFF_GLOBAL);
  wire hit_tsrc = (i_paddr == `TDMSC_OFF_TX_SRC);
  wire hit_rsrc = (i_paddr == `TDMSC_OFF_RX_SRC);
  wire hit_tctl = (i_paddr == `TDMSC_OFF_TX_CTRL);
  wire hit_rctl = (i_paddr == `TDMSC_OFF_RX_CTRL);
  wire hit_st = (i_paddr == `TDMSC_OFF_STATUS);
  wire mapped = hit_glb | hit_tsrc | hit_rsrc | hit_tctl | hit_rctl | hit_st;
  wire wr = acc && i_pwrite;
  wire ovr_set = stb_w[DRX] && !fifo_in_ready;
  wire undr_set = stb_w[DTX] && !hold_v_q;
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit_glb) begin
      rd_mux[7:0] = glb_q;
    end else if (hit_tsrc) begin
      rd_mux[0] = src_q[DTX];
    end else if (hit_rsrc) begin
      rd_mux[0] = src_q[DRX];
    end else if (hit_tctl) begin
      rd_mux[7:0] = ctrl_q[DTX];
    end else if (hit_rctl) begin
      rd_mux[7:0] = ctrl_q[DRX];
    end else if (hit_st) begin
      rd_mux[`TDMSC_ST_RX_RUN] = run_w[DRX];
      rd_mux[`TDMSC_ST_TX_RUN] = run_w[DTX];
      rd_mux[`TDMSC_ST_OVR] = ovr_q;
      rd_mux[`TDMSC_ST_UNDR] = undr_q;
      rd_mux[15:8] = links_w[DRX];
      rd_mux[23:16] = links_w[DTX];
      // Line rate code of the receive direction
      rd_mux[27:24] = {2'b00, rate_w[DRX]};
    end
  end

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ctl
      wire hit = (g == DTX) ? hit_tctl : hit_rctl;
      wire hit_src = (g == DTX) ? hit_tsrc : hit_rsrc;
      always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
          ctrl_q[g] <= `TDMSC_RST_CTRL; // RL18
          src_q[g] <= `TDMSC_RST_SRC; // RL7
        end else if (i_clk_en && wr) begin
          if (hit) begin
            // Bits 4:3 unused, so they stay zero and read back as zero
            ctrl_q[g][4:0] <= {2'b00, i_pwdata[2:0]};
            if (!en_w[g]) begin
              ctrl_q[g][7:5] <= i_pwdata[7:5]; // RL19
            end
          end
          // Swapping to the backup pair is a plain rewrite here
          if (hit_src) begin
            src_q[g] <= i_pwdata[`TDMSC_SRC_SEL]; // RL8
          end
        end
      end
    end
  endgenerate

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      glb_q <= `TDMSC_RST_GLOBAL; // RL7
      ovr_q <= 1'b0;
      undr_q <= 1'b0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (i_clk_en) begin
      o_pready <= acc;
      o_pslverr <= acc && !mapped;
      o_prdata <= (acc && !i_pwrite) ? rd_mux : 32'h0000_0000;
      if (wr && hit_glb) begin
        glb_q <= {3'b000, i_pwdata[`TDMSC_GC_CLOCK_REDUNDANCY_SELECT], 2'b00, i_pwdata[1:0]}; // RL9
      end
      // Set wins over a write-one clear in the same cycle
      if (ovr_set) begin
        ovr_q <= 1'b1;
      end else if (wr && hit_st && i_pwdata[`TDMSC_ST_OVR]) begin
        ovr_q <= 1'b0;
      end
      if (undr_set) begin
        undr_q <= 1'b1;
      end else if (wr && hit_st && i_pwdata[`TDMSC_ST_UNDR]) begin
        undr_q <= 1'b0;
      end
    end
  end
endmodule

// >>> tdmsc_map.vh
// Register map, field positions, reset values and counts of the clock and frame-sync front end
`ifndef TDMSC_MAP_VH
`define TDMSC_MAP_VH

// Byte offsets
`define TDMSC_OFF_GLOBAL 12'h000
`define TDMSC_OFF_TX_SRC 12'h004
`define TDMSC_OFF_RX_SRC 12'h008
`define TDMSC_OFF_TX_CTRL 12'h00c
`define TDMSC_OFF_RX_CTRL 12'h010
`define TDMSC_OFF_STATUS 12'h014

// Global control fields
`define TDMSC_GC_RX_EN 0
`define TDMSC_GC_TX_EN 1
`define TDMSC_GC_CLOCK_REDUNDANCY_SELECT 4

// Clock source field
`define TDMSC_SRC_SEL 0

// Direction control fields
`define TDMSC_CT_MODE 0
`define TDMSC_CT_RATE_LO 1
`define TDMSC_CT_RATE_HI 2
`define TDMSC_CT_DPOL 5
`define TDMSC_CT_FPOL 6
`define TDMSC_CT_SPOL 7

// Status fields
`define TDMSC_ST_RX_RUN 0
`define TDMSC_ST_TX_RUN 1
`define TDMSC_ST_OVR 2
`define TDMSC_ST_UNDR 3

// Reset values: double-rate clock, low rate, first source
`define TDMSC_RST_GLOBAL 8'h00
`define TDMSC_RST_SRC 1'b0
`define TDMSC_RST_CTRL 8'h00

// Line rate codes
`define TDMSC_RATE_LOW 2'b00
`define TDMSC_RATE_MID 2'b01
`define TDMSC_RATE_HIGH 2'b10

// Active link masks per rate
`define TDMSC_LINKS_LOW 8'hff
`define TDMSC_LINKS_MID 8'h0f
`define TDMSC_LINKS_HIGH 8'h03
`define TDMSC_LINKS_NONE 8'h00

// Frame length in data bits at the low rate: 128 timeslots of 8 bits
`define TDMSC_TS_LOW 10'h080
`define TDMSC_FRAME_BITS 14'h0400

// Buffer shape
`define TDMSC_FIFO_W 8
`define TDMSC_FIFO_D 16
`define TDMSC_FIFO_AW 4

`endif

// >>> tdmsc_sva.sv
// Port checker for the TDM clock and frame-sync front end
`timescale 1ns/1ns
module tdmsc_sva (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_clk_en,
  input wire i_psel,
  input wire i_penable,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [7:0] o_tx_data,
  input wire [7:0] o_tx_oe_n,
  input wire [7:0] o_rx_word,
  input wire o_rx_valid,
  input wire i_rx_ready
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  ////////////////////////////////////////////////////////////////////////////
  a_pready_wait: assert property (i_psel && i_penable && !o_pready && i_clk_en |=> o_pready)
    else $error("pready not one cycle after access");
  a_pready_pulse: assert property (o_pready && i_clk_en |=> !o_pready)
    else $error("pready longer than one cycle");
  a_pready_cause: assert property ($rose(o_pready) |-> $past(i_psel && i_penable))
    else $error("pready without access");
  a_slverr_pair: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_prdata_idle: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("prdata not zero outside answer");
  a_oe_masks: assert property (~o_tx_oe_n inside {8'hff, 8'h0f, 8'h03, 8'h00})
    else $error("driven links not a rate mask");
  a_released_zero: assert property ((o_tx_data & o_tx_oe_n) == 8'h00)
    else $error("released link carries data");
  a_rx_hold: assert property (o_rx_valid && !i_rx_ready && i_clk_en |=>
    o_rx_valid && $stable(o_rx_word))
    else $error("rx word dropped or changed while stalled");
  a_freeze: assert property (!i_clk_en |=> $stable(o_tx_oe_n) && $stable(o_rx_valid))
    else $error("state moved while clock enable low");

  c_slverr: cover property (o_pslverr);
  c_rx_take: cover property (o_rx_valid && i_rx_ready);
  c_all_drive: cover property (o_tx_oe_n == 8'h00);
endmodule

bind tdmsc_top tdmsc_sva chk_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
  .i_psel(i_psel), .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_tx_data(o_tx_data), .o_tx_oe_n(o_tx_oe_n),
  .o_rx_word(o_rx_word), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready));

// >>> tdmsc_link_model.sv
// Far-end TDM link: two clock and sync pairs plus receive data
`timescale 1ns/1ns
module tdmsc_link_model (
  output wire o_clk_a,
  output wire o_fs_a,
  output wire o_clk_b,
  output wire o_fs_b,
  output logic [7:0] o_data
);
  logic s = 1'b0;
  logic c = 1'b0;
  logic f = 1'b1;
  // Unselected pair stands still, sync parked high
  assign o_clk_a = s ? 1'b0 : c;
  assign o_fs_a = s ? 1'b1 : f;
  assign o_clk_b = s ? c : 1'b0;
  assign o_fs_b = s ? f : 1'b1;
  initial o_data = 8'h5a;

  ////////////////////////////////////////////////////////////////////////////
  // Clock runs only inside the frame task, so idle time gives no edges
  task frame(input logic sel, input logic pol, input int n, input int early);
    int i;
    begin
      #137;
      s = sel;
      f = !pol;
      #2000;
      // Sync and data change mid low phase, so both clock edges see them settled
      for (i = 0; i < n; i++) begin
        #200;
        f = (i == 0 || i == early) ? pol : !pol;
        o_data = o_data + 8'h35;
        #200 c = 1'b1;
        #400 c = 1'b0;
      end
      f = !pol;
      o_data = ~o_data;
    end
  endtask
endmodule

// >>> tb_tdm_serial_clock_frame_select.sv
// Self-checking bench for the TDM clock and frame-sync front end
`timescale 1ns/1ns
`include "tdmsc_map.vh"
module tb_tdm_serial_clock_frame_select;
  logic i_ref_clk, i_nrst, i_clk_en, i_psel, i_penable, i_pwrite, i_rx_ready, i_tx_valid, err;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, rd, r, rb;
  logic [7:0] tx_last = 8'h00;
  logic [31:0] seed = 32'h0000_953f;
  logic [7:0] i_tx_word, exp_mask, oe_seen;
  logic [1:0] tr, rr;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_rx_valid, o_tx_ready, ca, fa, cb, fb;
  wire [7:0] o_tx_data, o_tx_oe_n, o_rx_word, rxd;
  int n_errors, n_tests, n_rx, k;

  tdmsc_top dut_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_first_serial_clock_in(ca), .i_first_frame_sync_in(fa), .i_second_serial_clock_in(cb),
    .i_second_frame_sync_in(fb), .i_rx_data(rxd), .o_tx_data(o_tx_data),
    .o_tx_oe_n(o_tx_oe_n), .o_rx_word(o_rx_word), .o_rx_valid(o_rx_valid),
    .i_rx_ready(i_rx_ready), .i_tx_word(i_tx_word), .i_tx_valid(i_tx_valid),
    .o_tx_ready(o_tx_ready));
  tdmsc_link_model link_u (.o_clk_a(ca), .o_fs_a(fa), .o_clk_b(cb), .o_fs_b(fb), .o_data(rxd));

  ////////////////////////////////////////////////////////////////////////////
  function [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  endfunction
  function [7:0] lmask(input [1:0] rate);
    case (rate)
      2'b00: lmask = 8'hff;
      2'b01: lmask = 8'h0f;
      2'b10: lmask = 8'h03;
      default: lmask = 8'h00;
    endcase
  endfunction
  task chk(input [31:0] got, input [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Holds the request until pready is sampled high at a rising edge
  task apb(input logic w, input [11:0] a, input [31:0] d);
    int n;
    begin
      @(posedge i_ref_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
        @(posedge i_ref_clk);
        n++;
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      chk(n, 2, "pready latency");
    end
  endtask
  task finish_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    rb = xs();
    i_rx_ready <= rb[0];
    if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1) begin
      n_rx++;
      chk(o_rx_word & ~exp_mask, 0, "inactive link data");
    end
    // Valid stays high, so a word is taken exactly where ready stands
    if (o_tx_ready === 1'b1 && i_clk_en === 1'b1) begin
      chk(o_tx_data, tx_last & ~o_tx_oe_n, "tx link data");
      tx_last = i_tx_word;
      i_tx_word <= rb[15:8];
    end
    oe_seen <= oe_seen | ~o_tx_oe_n;
  end
  initial begin
    #(60000 * 100);
    n_errors++;
    finish_test;
  end
  initial begin
    {i_nrst, i_psel, i_penable, i_pwrite, i_rx_ready, i_paddr, i_pwdata} = '0;
    {i_clk_en, i_tx_valid, i_tx_word, exp_mask, oe_seen} = {2'b11, 8'h00, 8'hff, 8'h00};
    {n_errors, n_tests, n_rx} = '0;
    repeat (12) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    for (k = 0; k < 5; k++) begin
      apb(1'b0, 12'(k * 4), 0);
      chk(rd, 0, "reset value");
    end
    apb(1'b0, 12'h018, 0);
    chk(err, 1, "unmapped read error");
    chk(rd, 0, "unmapped read data");
    apb(1'b1, 12'hffc, 32'hffff_ffff);
    chk(err, 1, "unmapped write");
    for (k = 0; k < 8; k++) begin
      r = xs();
      tr = k[1:0];
      rr = k[2] ? r[1:0] : tr;
      apb(1'b1, `TDMSC_OFF_TX_CTRL, {29'h0, tr, 1'b0});
      apb(1'b1, `TDMSC_OFF_RX_CTRL, {29'h0, r[1:0], 1'b0});
      apb(1'b1, `TDMSC_OFF_GLOBAL, {27'h0, k[2], 4'h0});
      apb(1'b0, `TDMSC_OFF_STATUS, 0);
      chk(rd[25:8], {rr, lmask(tr), lmask(rr)}, "rate link masks");
    end
    apb(1'b1, `TDMSC_OFF_GLOBAL, 32'h1);
    apb(1'b1, `TDMSC_OFF_RX_CTRL, 32'hff);
    apb(1'b0, `TDMSC_OFF_RX_CTRL, 0);
    chk(rd, 32'h07, "protected fields");
    r = xs() & 32'he7;
    apb(1'b1, `TDMSC_OFF_TX_CTRL, r);
    apb(1'b0, `TDMSC_OFF_TX_CTRL, 0);
    chk(rd, r, "tx control readback");
    i_clk_en <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_clk_en <= 1'b1;
    // Shared mode: receive settings written here must be ignored
    apb(1'b1, `TDMSC_OFF_GLOBAL, 0);
    apb(1'b1, `TDMSC_OFF_TX_SRC, 0);
    apb(1'b1, `TDMSC_OFF_TX_CTRL, 0);
    apb(1'b1, `TDMSC_OFF_RX_SRC, 1);
    apb(1'b1, `TDMSC_OFF_RX_CTRL, 32'h03);
    apb(1'b1, `TDMSC_OFF_GLOBAL, 32'h3);
    k = n_rx;
    #10 oe_seen = 8'h00;
    link_u.frame(1'b0, 1'b0, 1044, 300);
    repeat (40) @(posedge i_ref_clk);
    chk(n_rx - k, 1024, "low rate frame words");
    chk(oe_seen, 8'hff, "all eight links driven");
    apb(1'b1, `TDMSC_OFF_GLOBAL, 0);
    apb(1'b1, `TDMSC_OFF_RX_SRC, 1);
    apb(1'b1, `TDMSC_OFF_RX_CTRL, 32'h83);
    apb(1'b1, `TDMSC_OFF_GLOBAL, 32'h11);
    exp_mask = 8'h0f;
    k = n_rx;
    #10 oe_seen = 8'h00;
    link_u.frame(1'b1, 1'b1, 2068, 500);
    repeat (40) @(posedge i_ref_clk);
    chk(n_rx - k, 2048, "mid rate frame words");
    chk(oe_seen, 8'h00, "tx stays released");
    // Falling edges for sync and data, single clock, low rate, first pair
    apb(1'b1, `TDMSC_OFF_GLOBAL, 32'h10);
    apb(1'b1, `TDMSC_OFF_RX_SRC, 0);
    apb(1'b1, `TDMSC_OFF_RX_CTRL, 32'he1);
    apb(1'b1, `TDMSC_OFF_GLOBAL, 32'h11);
    exp_mask = 8'hff;
    k = n_rx;
    link_u.frame(1'b0, 1'b1, 1044, 700);
    repeat (40) @(posedge i_ref_clk);
    chk(n_rx - k, 1024, "falling edge frame words");
    finish_test;
  end
endmodule
